// File: hw/etd_top.v
// Dual eight-bit timer/divider with Avalon-MM register slave
`timescale 1ns/1ns
`include "etd_defs.vh"
module etd_top (
   input  wire        clk,                // System clock
   input  wire        rst,                // Synchronous reset, high
   input  wire [3:0]  avs_address,        // Byte address
   input  wire        avs_read,           // Read strobe
   input  wire        avs_write,          // Write strobe
   input  wire [31:0] avs_writedata,      // Write data
   input  wire [3:0]  avs_byteenable,     // Byte lanes
   output reg  [31:0] avs_readdata,       // Read data
   output wire        avs_waitrequest,    // Stall
   input  wire        low_speed_mode,     // Low-speed or sleep mode
   input  wire        prescale_tap_select,// Slowest tap from low clock
   input  wire        low_freq_tick,      // Low clock tick pulse
   input  wire [1:0]  event_in_pin,       // External event pins
   output wire [1:0]  divider_out_pin,    // Divider outputs
   output wire [1:0]  match_irq           // Match pulses
);
   // ****************************************
   // Register storage
   // ****************************************
   reg  [7:0]  timer_ctrl_reg_r [0:1];    // Control per channel
   reg  [7:0]  compare_value_reg_r [0:1]; // Compare per channel
   reg  [1:0]  ff_wr;                     // Flip-flop load strobes
   reg         ack_r;                     // Answer one cycle later
   reg  [`ETD_PS_W-1:0] ps_r;             // High clock prescaler
   reg  [`ETD_PS_W-1:0] ps_nxt;           // Prescaler next value
   reg  [2:0]  lf_r;                      // Low clock divide by 8
   wire [7:0]  cnt0, cnt1;                // Channel counters
   wire [1:0]  ff;                        // Channel flip-flops
   wire [1:0]  fall;                      // Event edges
   reg  [7:0]  ticks;                     // Tick per select code
   wire        req = avs_read | avs_write;

   // Decode register index from byte address
   function [1:0] idx;
      input [3:0] a;
      begin
         idx = a[3:2];
      end
   endfunction

   // Rising-edge tap pulse of prescaler bit
   function tapp;
      input [`ETD_PS_W-1:0] cur;
      input [`ETD_PS_W-1:0] nx;
      input integer b;
      begin
         tapp = ~cur[b] & nx[b];
      end
   endfunction

   // ****************************************
   // Avalon slave: one wait state per access
   // ****************************************
   assign avs_waitrequest = req & ~ack_r;

   always @(posedge clk) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // Register writes, taken on the ack edge
   always @(posedge clk) begin
      if (rst) begin
         timer_ctrl_reg_r[0]    <= `ETD_CTL_RST;
         timer_ctrl_reg_r[1]    <= `ETD_CTL_RST;
         compare_value_reg_r[0] <= `ETD_CMP_RST;
         compare_value_reg_r[1] <= `ETD_CMP_RST;
         ff_wr <= 2'b00;
      end else begin
         ff_wr <= 2'b00;
         if (avs_write && ack_r && avs_byteenable[0]) begin
            case (idx(avs_address))
               2'd0: begin
                  timer_ctrl_reg_r[0] <= avs_writedata[7:0];
                  ff_wr[0] <= 1'b1;
               end
               2'd1: begin
                  compare_value_reg_r[0] <= avs_writedata[7:0];
               end
               2'd2: begin
                  timer_ctrl_reg_r[1] <= avs_writedata[7:0];
                  ff_wr[1] <= 1'b1;
               end
               default: begin
                  compare_value_reg_r[1] <= avs_writedata[7:0];
               end
            endcase
         end
      end
   end

   // Read mux: control shows live flip-flop, compare upper has count
   always @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_r) begin
         case (idx(avs_address))
            2'd0: avs_readdata <= {24'h000000, ff[0],
                                   timer_ctrl_reg_r[0][6:0]};
            2'd1: avs_readdata <= {16'h0000, cnt0,
                                   compare_value_reg_r[0]};
            2'd2: avs_readdata <= {24'h000000, ff[1],
                                   timer_ctrl_reg_r[1][6:0]};
            default: avs_readdata <= {16'h0000, cnt1,
                                      compare_value_reg_r[1]};
         endcase
      end
   end

   // ****************************************
   // Prescaler and tap pulses
   // ****************************************
   always @* begin
      ps_nxt = ps_r + {{(`ETD_PS_W-1){1'b0}}, 1'b1};
   end

   always @(posedge clk) begin
      if (rst) begin
         ps_r <= {`ETD_PS_W{1'b0}};
         lf_r <= 3'h0;
      end else begin
         ps_r <= ps_nxt;
         if (low_freq_tick) begin
            lf_r <= lf_r + 3'h1;
         end
      end
   end

   always @* begin
      ticks = 8'h00;
      if (prescale_tap_select | low_speed_mode) begin
         ticks[0] = low_freq_tick & (lf_r == 3'h7);
      end else begin
         ticks[0] = tapp(ps_r, ps_nxt, `ETD_TAP_11) &
                    (ps_nxt[`ETD_TAP_11-1:0] == 10'h000);
      end
      ticks[1] = ps_nxt[`ETD_TAP_7:0] == 7'h00;
      ticks[2] = ps_nxt[`ETD_TAP_5:0] == 5'h00;
      ticks[3] = ps_nxt[`ETD_TAP_3:0] == 3'h0;
   end

   // ****************************************
   // Channels
   // ****************************************
   etd_edge u_e0 (.clk(clk), .rst(rst), .pin(event_in_pin[0]),
                  .fall(fall[0]));
   etd_edge u_e1 (.clk(clk), .rst(rst), .pin(event_in_pin[1]),
                  .fall(fall[1]));

   // each channel clocked by own select; no cascade path
   // mode and select fields per channel
   etd_chan u_c0 (
      .clk(clk), .rst(rst),
      .mode(timer_ctrl_reg_r[0][`ETD_CTL_MODE_HI:`ETD_CTL_MODE_LO]),
      .start(timer_ctrl_reg_r[0][`ETD_CTL_START]),
      .csel(timer_ctrl_reg_r[0][`ETD_CTL_CSEL_HI:`ETD_CTL_CSEL_LO]),
      .cmp(compare_value_reg_r[0]), .ff_wr(ff_wr[0]),
      .ff_val(timer_ctrl_reg_r[0][`ETD_CTL_FF]),
      .low_spd(low_speed_mode), .ticks(ticks), .ev_fall(fall[0]),
      .cnt_r(cnt0), .ff_r(ff[0]), .irq_r(match_irq[0]));
   etd_chan u_c1 (
      .clk(clk), .rst(rst),
      .mode(timer_ctrl_reg_r[1][`ETD_CTL_MODE_HI:`ETD_CTL_MODE_LO]),
      .start(timer_ctrl_reg_r[1][`ETD_CTL_START]),
      .csel(timer_ctrl_reg_r[1][`ETD_CTL_CSEL_HI:`ETD_CTL_CSEL_LO]),
      .cmp(compare_value_reg_r[1]), .ff_wr(ff_wr[1]),
      .ff_val(timer_ctrl_reg_r[1][`ETD_CTL_FF]),
      .low_spd(low_speed_mode), .ticks(ticks), .ev_fall(fall[1]),
      .cnt_r(cnt1), .ff_r(ff[1]), .irq_r(match_irq[1]));

   assign divider_out_pin = ~ff;
endmodule

// File: hw/etd_defs.vh
// Constants of the dual eight-bit timer and divider block
`ifndef ETD_DEFS_VH
`define ETD_DEFS_VH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ETD_OFS_CTRL0   4'h0
`define ETD_OFS_CMP0    4'h4
`define ETD_OFS_CTRL1   4'h8
`define ETD_OFS_CMP1    4'hC
`define ETD_ADDR_W      4
// ****************************************
// Control register fields
// ****************************************
`define ETD_CTL_MODE_LO 0
`define ETD_CTL_MODE_HI 2
`define ETD_CTL_START   3
`define ETD_CTL_CSEL_LO 4
`define ETD_CTL_CSEL_HI 6
`define ETD_CTL_FF      7
`define ETD_CTL_RST     8'h00
`define ETD_CMP_RST     8'hFF
// ****************************************
// Mode and clock select codes
// ****************************************
`define ETD_MODE_TMR    3'h0
`define ETD_MODE_DIV    3'h1
`define ETD_CS_SLOW     3'h0
`define ETD_CS_D7       3'h1
`define ETD_CS_D5       3'h2
`define ETD_CS_D3       3'h3
`define ETD_CS_LF       3'h4
`define ETD_CS_HALF     3'h5
`define ETD_CS_FULL     3'h6
`define ETD_CS_PIN      3'h7
// ****************************************
// Prescaler tap positions
// ****************************************
`define ETD_PS_W        11
`define ETD_TAP_11      10
`define ETD_TAP_7       6
`define ETD_TAP_5       4
`define ETD_TAP_3       2
`define ETD_TAP_LF8     2
`endif

// File: hw/etd_edge.v
// Event pin synchroniser with falling edge pulse
`timescale 1ns/1ns
module etd_edge (
   input  wire clk,   // System clock
   input  wire rst,   // Synchronous reset
   input  wire pin,   // Raw event pin
   output wire fall   // One-cycle pulse on falling edge
);
   // ****************************************
   // Synchroniser and edge detector
   // ****************************************
   reg s1_r;   // First stage, read only by s2_r
   reg s2_r;   // Second stage
   reg s3_r;   // Delayed copy for edge detect

   always @(posedge clk) begin
      if (rst) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // High then low gives a single pulse
   assign fall = s3_r & ~s2_r;
endmodule

// File: hw/etd_chan.v
// One eight-bit timer, event counter and divider channel
`timescale 1ns/1ns
`include "etd_defs.vh"
module etd_chan (
   input  wire       clk,      // System clock
   input  wire       rst,      // Synchronous reset
   input  wire [2:0] mode,     // Mode field
   input  wire       start,    // Run control
   input  wire [2:0] csel,     // Clock select field
   input  wire [7:0] cmp,      // Compare value
   input  wire       ff_wr,    // Software load of flip-flop
   input  wire       ff_val,   // Value for flip-flop load
   input  wire       low_spd,  // Low-speed power mode
   input  wire [7:0] ticks,    // Tick pulses per clock select code
   input  wire       ev_fall,  // Event pin falling edge
   output reg  [7:0] cnt_r,    // Counter value
   output reg        ff_r,     // Output flip-flop
   output reg        irq_r     // Match pulse
);
   // ****************************************
   // Tick selection
   // ****************************************
   reg tick;   // Count enable this cycle
   reg legal;  // Clock choice allowed in current mode

   always @* begin
      tick  = 1'b0;
      legal = 1'b0;
      if (mode == `ETD_MODE_TMR && csel == `ETD_CS_PIN) begin
         tick  = ev_fall;   // count falling edges
         legal = 1'b1;
      end else if (csel <= `ETD_CS_D3) begin
         tick  = ticks[csel];
         legal = ~low_spd | (csel == `ETD_CS_SLOW);
      end
      tick = tick & legal;
   end

   wire run  = start & ((mode == `ETD_MODE_TMR) | (mode == `ETD_MODE_DIV));
   // Count after this tick; a match is the tick that reaches compare
   wire [7:0] cnt_inc = cnt_r + 8'h01;
   wire hit  = run & tick & (cnt_inc == cmp);

   // ****************************************
   // Counter, flip-flop and match pulse
   // ****************************************
   always @(posedge clk) begin
      if (rst) begin
         cnt_r <= 8'h00;
         ff_r  <= 1'b0;   // reset clears
         irq_r <= 1'b0;
      end else begin
         irq_r <= 1'b0;
         if (!start) begin
            cnt_r <= 8'h00;   // Stop clears counter
         end else if (hit) begin
            cnt_r <= 8'h00;
            irq_r <= 1'b1;
         end else if (run & tick) begin
            cnt_r <= cnt_inc;
         end
         if (hit && mode == `ETD_MODE_DIV) begin
            ff_r <= ~ff_r;
         end else if (ff_wr) begin
            ff_r <= ff_val;
         end
      end
   end
   // Compare is made against the incremented count, so the period
   // is cmp ticks (256 ticks when cmp is zero) and the counter returns to zero on the match tick.
endmodule

// File: testbench/etd_top_asserts.sv
// Port checker for the dual timer/divider block
`timescale 1ns/1ns
module etd_chk (
   input wire        clk,             // System clock
   input wire        rst,             // Synchronous reset
   input wire [3:0]  avs_address,     // Byte address
   input wire        avs_read,        // Read strobe
   input wire        avs_write,       // Write strobe
   input wire [31:0] avs_writedata,   // Write data
   input wire [3:0]  avs_byteenable,  // Byte lanes
   input wire [31:0] avs_readdata,    // Read data
   input wire        avs_waitrequest, // Stall
   input wire [1:0]  divider_out_pin, // Divider outputs
   input wire [1:0]  match_irq        // Match pulses
);
   reg run_r; // Shadow of channel 0 start bit
   // ****************************************
   // Shadow of the run control
   // ****************************************
   always @(posedge clk) begin
      if (rst)
         run_r <= 1'b0;
      else if (avs_write && !avs_waitrequest && avs_address == 4'h0
               && avs_byteenable[0])
         run_r <= avs_writedata[3];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_wait_first; $rose(avs_read || avs_write) |-> avs_waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait state");
   property p_wait_one;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait too long");
   property p_wait_idle; !avs_read && !avs_write |-> !avs_waitrequest;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("idle stall");
   property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_irq0_pulse; match_irq[0] |=> !match_irq[0]; endproperty
   a_irq0_pulse: assert property (p_irq0_pulse)
      else $error("match 0 pulse too long");
   property p_irq1_pulse; match_irq[1] |=> !match_irq[1]; endproperty
   a_irq1_pulse: assert property (p_irq1_pulse)
      else $error("match 1 pulse too long");
   property p_reset_vals; $fell(rst) |->
      divider_out_pin == 2'h3 && match_irq == 2'h0 && avs_readdata == 32'h0;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("bad value after reset");
   property p_pin_cause; $changed(divider_out_pin) |->
      ($past(avs_write, 2) || $past(rst)) or ##[0:2] (match_irq != 2'h0);
   endproperty
   a_pin_cause: assert property (p_pin_cause)
      else $error("pin moved without match or write");
   property p_stop_quiet; !run_r && !$past(run_r) |-> !match_irq[0];
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("match while stopped");
endmodule
bind etd_top etd_chk chk (.clk(clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .divider_out_pin(divider_out_pin), .match_irq(match_irq));

// File: testbench/etd_partner.sv
// External event pulse source
`timescale 1ns/1ns
module etd_partner (
   input  wire       clk,    // System clock
   input  wire       fire,   // Start a burst
   input  wire [3:0] n,      // Falling edges in burst
   input  wire [3:0] hold,   // Cycles per level, at least MIN_LVL
   output reg        ev_pin, // Event pin, idles high
   output reg        busy    // Burst in progress
);
   // ****************************************
   // Burst generator
   // ****************************************
   localparam MIN_LVL = 8; // Two machine cycles: one sixteenth rate

   initial begin
      ev_pin = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge clk);
         if (fire) begin
            busy <= 1'b1;
            repeat (n) begin
               repeat (hold < MIN_LVL ? MIN_LVL : hold) @(posedge clk);
               ev_pin <= 1'b0;
               repeat (hold < MIN_LVL ? MIN_LVL : hold) @(posedge clk);
               ev_pin <= 1'b1;
            end
            @(posedge clk);
            busy <= 1'b0;
         end
      end
   end
endmodule

// File: testbench/eight_bit_timer_divider_test.sv
// Self-checking bench of the dual timer/divider block
`timescale 1ns/1ns
module eight_bit_timer_divider_test;
   reg         clk = 0;        // Clock
   reg         rst = 1;        // Reset
   reg  [3:0]  adr = 0;        // Address
   reg         rd = 0;         // Read
   reg         wr = 0;         // Write
   reg  [31:0] wd = 0;         // Write data
   reg  [3:0]  be = 0;         // Lanes
   reg         lsm = 0;        // Low-speed mode
   reg         pts = 0;        // Slow tap source
   reg         lft = 0;        // Low clock tick
   reg  [1:0]  lc = 0;         // Tick divider
   reg         fire = 0;       // Burst start
   reg  [3:0]  nev = 0;        // Edges per burst
   reg  [3:0]  hld = 2;        // Level length
   wire [31:0] rdat;           // Read data
   wire        wt;             // Wait request
   wire        evp;            // Event pin
   wire        pbusy;          // Burst busy
   wire [1:0]  pin;            // Divider pins
   wire [1:0]  irq;            // Match pulses
   integer     mismatches = 0; // Mismatch count
   integer     n_tests = 0;    // Compare count
   integer     nirq = 0;       // Channel 1 matches
   integer     c;              // Cycle count
   integer     k;              // Loop index
   reg  [31:0] r;              // Read data taken
   reg         p;              // Saved pin
   etd_top uut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wt), .low_speed_mode(lsm),
      .prescale_tap_select(pts), .low_freq_tick(lft),
      .event_in_pin({evp, evp}), .divider_out_pin(pin), .match_irq(irq));
   etd_partner src (.clk(clk), .fire(fire), .n(nev), .hold(hld),
      .ev_pin(evp), .busy(pbusy));
   initial forever #2 clk = ~clk;
   // Low clock tick every fourth cycle, match counter
   always @(posedge clk) begin
      lc <= lc + 2'h1;
      lft <= (lc == 2'h0);
      if (irq[1] === 1'b1) nirq <= nirq + 1;
   end
   task check(input string nm, input [31:0] got, input [31:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task bus(input w, input [3:0] a, input [31:0] d);
      adr <= a;
      wd <= d;
      be <= 4'h1;
      rd <= !w;
      wr <= w;
      @(posedge clk);
      while (wt !== 1'b0) @(posedge clk);
      r = rdat;
      rd <= 0;
      wr <= 0;
      @(posedge clk);
   endtask
   task wait_irq(input integer lim);
      c = 0;
      do begin @(posedge clk); c = c + 1; end
      while (irq[0] !== 1'b1 && c < lim);
   endtask
   task wait_pin;
      p = pin[0];
      c = 0;
      do begin @(posedge clk); c = c + 1; end
      while (pin[0] === p && c < 500);
   endtask
   task burst(input [3:0] n, input [3:0] h);
      nev <= n;
      hld <= h;
      fire <= 1;
      @(posedge clk);
      fire <= 0;
      @(posedge clk);
      while (pbusy) @(posedge clk);
      repeat (8) @(posedge clk);
   endtask
   task stop_test;
      $display("%0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task t_reset;
      bus(1, 4'h4, 32'h5);
      adr <= 4'h4;
      be <= 4'h0;
      wd <= 32'hAA;
      wr <= 1;
      @(posedge clk);
      while (wt !== 1'b0) @(posedge clk);
      wr <= 0;
      @(posedge clk);
      bus(0, 4'h4, 0);
      check("cmp lanes", r[7:0], 8'h05);
      bus(0, 4'h0, 0);
      check("ctrl reset", r[7:0], 8'h00);
      check("pins reset", pin, 2'h3);
      $display("test reset done");
   endtask
   task t_taps;
      // nonzero compare; two taps per match
      bus(1, 4'h4, 32'h2);
      for (k = 0; k < 7; k = k + 1) begin
         bus(1, 4'h0, 32'h0);
         bus(1, 4'h0, k * 16 + 8);
         wait_irq(k < 4 ? 5000 : 300);
         wait_irq(k < 4 ? 5000 : 300);
         check("tap period", c, k < 4 ? 1 << (k == 0 ? 12 : 10 - 2 * k)
            : 300);
      end
      check("timer pin", pin[0], 1);
      $display("test taps done");
   endtask
   task t_slow;
      pts <= 1;
      for (k = 0; k < 3; k = k + 1) begin
         lsm <= k > 0;
         bus(1, 4'h0, 32'h0);
         bus(1, 4'h0, k == 2 ? 32'h38 : 32'h08);
         wait_irq(300);
         wait_irq(300);
         check("slow tap", c, k == 2 ? 300 : 64);
      end
      bus(1, 4'h0, 32'h0);
      lsm <= 0;
      pts <= 0;
      $display("test slow done");
   endtask
   task t_div;
      bus(1, 4'h4, 32'h3);
      bus(1, 4'h0, 32'h39);
      wait_pin;
      wait_pin;
      // Three ticks of eight clocks per half period
      check("half period", c, 24);
      bus(0, 4'h0, 0);
      check("pin vs ff", pin[0], !r[7]);
      p = pin[0];
      bus(1, 4'h0, {r[7], 7'h31});
      repeat (100) @(posedge clk);
      check("held pin", pin[0], p);
      bus(1, 4'h0, 32'h31);
      @(posedge clk);
      check("forced high", pin[0], 1);
      bus(1, 4'h0, 32'hB1);
      @(posedge clk);
      check("forced low", pin[0], 0);
      bus(1, 4'h0, 32'h31);
      $display("test divider done");
   endtask
   task t_event;
      // Third falling edge reaches compare
      bus(1, 4'hC, 32'h3);
      bus(1, 4'h8, 32'h78);
      burst(2, 2);
      bus(0, 4'hC, 0);
      check("event count", r[15:8], 2);
      check("no match", nirq, 0);
      burst(1, 7);
      bus(0, 4'hC, 0);
      check("cleared", r[15:8], 0);
      burst(3, 2);
      check("matches", nirq, 2);
      $display("test event done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      t_reset;
      t_taps;
      t_slow;
      t_div;
      t_event;
      stop_test;
   end
   initial begin
      repeat (60000) @(posedge clk);
      mismatches = mismatches + 1;
      stop_test;
   end
endmodule
